/* File: logic/srap_top.sv */
// Purpose: Pointer-based sequential access port to a 2K x 8 buffer
// Assumes: Host register strobes are one cycle and synchronous to CLK
// Notes:   Writes queue in a two-entry buffer; reads are prefetched
//
// Summary of operation
// - RAM reached via pointer and data registers
// - Low pointer write loads full address
// - Loaded address prefetched into holding register
// - Auto-increment advances address; reads also prefetch next
// - Data writes buffered, committed to RAM later
// - Slow arbitration halves the arbitration clock
// - Pointer readable after a burst
// - Four 512-byte pages chosen by page field
// - Offset bit adds 256 bytes
// - Command 0x23 transmits from page 0 upper half
// - Page start is page*512 plus offset*256
// - No page limit checks during reception
// - Slow arbitration resets to zero
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.svh"
module srap_top
(
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST,
    // Register port
    input  wire logic [2:0]             REG_ADDR,
    input  wire srap_pkg::srap_byte_type REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output srap_pkg::srap_byte_type     REG_RDATA,
    output logic                        WR_READY,
    // Page selection results
    output srap_pkg::srap_addr_type     TX_PAGE_BASE,
    output srap_pkg::srap_addr_type     RX_PAGE_BASE,
    output logic                        TX_ENABLE,
    output logic                        RX_ENABLE,
    // Network engine RAM channel
    input  wire logic                   ENG_REQ,
    input  wire logic                   ENG_WE,
    input  wire srap_pkg::srap_addr_type ENG_ADDR,
    input  wire srap_pkg::srap_byte_type ENG_WDATA,
    output logic                        ENG_DONE,
    output srap_pkg::srap_byte_type     ENG_RDATA
);
    import srap_pkg::*;

    srap_mem_if mem ();

    srap_port_state_type state_r;
    srap_port_state_type state_nxt;
    logic [7:0]          ptr_hi_r;
    logic [7:0]          fsetup_r;
    srap_addr_type       addr_r;
    srap_addr_type       addr_inc;
    logic [2:0]          ptr_hi_addr;
    logic [7:0]          addr_lo;
    srap_byte_type       pf_data_r;
    logic                pf_pend_r;
    srap_byte_type       rdata_r;
    srap_addr_type       tx_base_r;
    srap_addr_type       rx_base_r;
    logic                tx_go_r;
    logic                rx_go_r;
    srap_addr_type       cmd_base;
    logic [1:0]          cmd_page;
    logic                cmd_f;
    logic                wr_ptrh;
    logic                wr_ptrl;
    logic                wr_data;
    logic                rd_data;
    logic                wr_cmd;
    logic                autoinc;
    // Write buffer: two entries of address and byte
    srap_addr_type       fifo_addr [0:1];
    srap_byte_type       fifo_data [0:1];
    logic                fifo_wp_r;
    logic                fifo_rp_r;
    logic [1:0]          fifo_cnt_r;
    logic                push_valid;
    logic                push_ready;
    logic                pop_valid;
    logic                pop_ready;

    // Strobe decode by offset
    // indirect register access
    assign wr_ptrh = REG_WR && (REG_ADDR == `SRAP_OFS_PTRH);
    assign wr_ptrl = REG_WR && (REG_ADDR == `SRAP_OFS_PTRL);
    assign wr_data = REG_WR && (REG_ADDR == `SRAP_OFS_DATA);
    assign rd_data = REG_RD && (REG_ADDR == `SRAP_OFS_DATA);
    assign wr_cmd  = REG_WR && (REG_ADDR == `SRAP_OFS_CMD);
    assign autoinc = ptr_hi_r[`SRAP_PH_AUTOINC];
    assign ptr_hi_addr = ptr_hi_r[2:0];
    assign addr_lo     = addr_r[7:0];
    assign addr_inc = addr_r + 11'h001;

    // High pointer keeps control bits and upper address bits
    // auto-increment in high pointer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ptr_hi_r <= `SRAP_PTRH_RST;
        else if (wr_ptrh)
            ptr_hi_r <= REG_WDATA;
    end

    // Setup register; only the slow arbitration bit acts
    // slow arbitration resets low
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            fsetup_r <= `SRAP_FSETUP_RST;
        else if (REG_WR && (REG_ADDR == `SRAP_OFS_FSETUP))
            fsetup_r <= REG_WDATA;
    end

    assign mem.slow = fsetup_r[`SRAP_FS_SLOW_ARB];

    // RAM address pointer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            addr_r <= `SRAP_ADDR_RST;
        else if (wr_ptrl)
            addr_r <= {ptr_hi_addr, REG_WDATA};
        else if ((rd_data || (wr_data && push_ready)) && autoinc)
            addr_r <= addr_inc;
    end

    // Prefetch request; a new request wins over the issue clear
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            pf_pend_r <= 1'b0;
        else if (wr_ptrl || (rd_data && autoinc))
            pf_pend_r <= 1'b1;
        else if ((state_r == SRAP_IDLE) && (state_nxt == SRAP_READ))
            pf_pend_r <= 1'b0;
    end

    // Holding register for prefetched byte
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            pf_data_r <= 8'h00;
        else if ((state_r == SRAP_READ) && mem.done)
            pf_data_r <= mem.rdata;
    end

    assign push_valid = wr_data;
    assign push_ready = (fifo_cnt_r != 2'h2);
    assign pop_valid  = (fifo_cnt_r != 2'h0);
    assign pop_ready  = (state_r == SRAP_WRITE) && mem.done;
    assign WR_READY   = push_ready;

    // One slot per entry, loaded when the write pointer selects it
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_slot
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    fifo_addr[gi] <= `SRAP_ADDR_RST;
                    fifo_data[gi] <= 8'h00;
                end
                else if (push_valid && push_ready && (fifo_wp_r == gi))
                begin
                    fifo_addr[gi] <= addr_r;
                    fifo_data[gi] <= REG_WDATA;
                end
            end
        end
    endgenerate

    // Buffer pointers and fill count; a full buffer drops the write
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            fifo_wp_r  <= 1'b0;
            fifo_rp_r  <= 1'b0;
            fifo_cnt_r <= 2'h0;
        end
        else
        begin
            if (push_valid && push_ready)
                fifo_wp_r <= ~fifo_wp_r;
            if (pop_valid && pop_ready)
                fifo_rp_r <= ~fifo_rp_r;
            if ((push_valid && push_ready) && !(pop_valid && pop_ready))
                fifo_cnt_r <= fifo_cnt_r + 2'h1;
            else if (!(push_valid && push_ready) && (pop_valid && pop_ready))
                fifo_cnt_r <= fifo_cnt_r - 2'h1;
        end
    end

    // Memory port sequencer; buffered writes go before prefetch
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SRAP_IDLE:
                if (pop_valid)
                    state_nxt = SRAP_WRITE;
                else if (pf_pend_r)
                    state_nxt = SRAP_READ;
            SRAP_WRITE:
                if (mem.done)
                    state_nxt = SRAP_IDLE;
            SRAP_READ:
                if (mem.done)
                    state_nxt = SRAP_IDLE;
            default:
                state_nxt = SRAP_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            state_r <= SRAP_IDLE;
        else
            state_r <= state_nxt;
    end

    // Request drives; address of a read is the live pointer
    assign mem.req   = (state_r != SRAP_IDLE);
    assign mem.we    = (state_r == SRAP_WRITE);
    assign mem.addr  = (state_r == SRAP_WRITE) ? fifo_addr[fifo_rp_r]
                                                : addr_r;
    assign mem.wdata = fifo_data[fifo_rp_r];

    // Command decode and page base
    assign cmd_page = REG_WDATA[4:3];
    assign cmd_f  = REG_WDATA[`SRAP_CMD_OFFSET];
    assign cmd_base = 11'(cmd_page) * `SRAP_PAGE_BYTES
                    + (cmd_f ? `SRAP_HALF_BYTES : 11'h000);

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            tx_base_r <= `SRAP_ADDR_RST;
            rx_base_r <= `SRAP_ADDR_RST;
            tx_go_r   <= 1'b0;
            rx_go_r   <= 1'b0;
        end
        else
        begin
            tx_go_r <= wr_cmd && (REG_WDATA[2:0] == `SRAP_CMD_TX);
            rx_go_r <= wr_cmd && (REG_WDATA[2:0] == `SRAP_CMD_RX);
            if (wr_cmd && (REG_WDATA[2:0] == `SRAP_CMD_TX))
                tx_base_r <= cmd_base;
            if (wr_cmd && (REG_WDATA[2:0] == `SRAP_CMD_RX))
                rx_base_r <= cmd_base;
        end
    end

    assign TX_PAGE_BASE = tx_base_r;
    assign RX_PAGE_BASE = rx_base_r;
    assign TX_ENABLE    = tx_go_r;
    assign RX_ENABLE    = rx_go_r;

    // Read data one cycle after the strobe, zero elsewhere
    // pointer readback
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            rdata_r <= 8'h00;
        else if (!REG_RD)
            rdata_r <= 8'h00;
        else if (REG_ADDR == `SRAP_OFS_PTRH)
            rdata_r <= {ptr_hi_r[7:3], addr_r[10:8]};
        else if (REG_ADDR == `SRAP_OFS_PTRL)
            rdata_r <= addr_lo;
        else if (REG_ADDR == `SRAP_OFS_DATA)
            rdata_r <= pf_data_r;
        else if (REG_ADDR == `SRAP_OFS_FSETUP)
            rdata_r <= fsetup_r;
        else
            rdata_r <= 8'h00;
    end

    assign REG_RDATA = rdata_r;

    srap_ram_arb u_arb (
        .clk       (CLK),
        .rst       (RST),
        .mem       (mem.arb),
        .eng_req   (ENG_REQ),
        .eng_we    (ENG_WE),
        .eng_addr  (ENG_ADDR),
        .eng_wdata (ENG_WDATA),
        .eng_done  (ENG_DONE),
        .eng_rdata (ENG_RDATA)
    );

    chk_ptr_load:
        assert property (@(posedge CLK) disable iff (RST)
            wr_ptrl |=> addr_r == {$past(ptr_hi_addr), $past(REG_WDATA)})
        else $error("low pointer write did not load address");

    chk_pf_issue:
        assert property (@(posedge CLK) disable iff (RST)
            (wr_ptrl && fifo_cnt_r == 2'h0 && !mem.req)
            |=> ##[0:8] (state_r == SRAP_READ))
        else $error("prefetch not started after pointer load");

    chk_auto_inc:
        assert property (@(posedge CLK) disable iff (RST)
            (rd_data && autoinc && !wr_ptrl) |=> addr_r == $past(addr_inc))
        else $error("pointer did not advance");

    chk_data_read:
        assert property (@(posedge CLK) disable iff (RST)
            rd_data |=> REG_RDATA == $past(pf_data_r))
        else $error("data read mismatch");

    chk_wr_buffer:
        assert property (@(posedge CLK) disable iff (RST)
            (wr_data && push_ready) |=> pop_valid)
        else $error("data write not buffered");

    chk_page_base:
        assert property (@(posedge CLK) disable iff (RST)
            (wr_cmd && REG_WDATA[2:0] == `SRAP_CMD_RX)
            |=> RX_ENABLE && RX_PAGE_BASE == {$past(cmd_page), $past(cmd_f),
                                              8'h00})
        else $error("receive page base wrong");

    chk_cmd_23:
        assert property (@(posedge CLK) disable iff (RST)
            (wr_cmd && REG_WDATA == 8'h23)
            |=> TX_ENABLE && TX_PAGE_BASE == 11'h100)
        else $error("command 0x23 decode wrong");

    chk_slow_reset:
        assert property (@(posedge CLK)
            ($past(RST) && !RST) |-> !mem.slow)
        else $error("slow arbitration set after reset");

    chk_ptr_read:
        assert property (@(posedge CLK) disable iff (RST)
            (REG_RD && REG_ADDR == `SRAP_OFS_PTRL)
            |=> REG_RDATA == $past(addr_lo))
        else $error("pointer readback wrong");
endmodule : srap_top
`default_nettype wire

/* File: logic/srap_defs.svh */
// Purpose: Offsets, field positions, reset values of the RAM access port
// Assumes: Byte-wide register port with a 3-bit offset
// Notes:   Definitions only
`ifndef SRAP_DEFS_SVH
`define SRAP_DEFS_SVH
// Register offsets
`define SRAP_OFS_CMD     3'h1
`define SRAP_OFS_PTRH    3'h2
`define SRAP_OFS_PTRL    3'h3
`define SRAP_OFS_DATA    3'h4
`define SRAP_OFS_FSETUP  3'h7
// Field positions
`define SRAP_PH_AUTOINC  7
`define SRAP_FS_SLOW_ARB 0
`define SRAP_CMD_OFFSET  5
// Command codes in the low three bits
`define SRAP_CMD_TX      3'h3
`define SRAP_CMD_RX      3'h4
// Page geometry
`define SRAP_PAGE_BYTES  11'h200
`define SRAP_HALF_BYTES  11'h100
// Reset values
`define SRAP_PTRH_RST    8'h00
`define SRAP_FSETUP_RST  8'h00
`define SRAP_ADDR_RST    11'h000
`endif

/* File: logic/srap_pkg.sv */
// Purpose: Types shared by the RAM access port modules
// Assumes: None
// Notes:   Constants live in srap_defs.svh
package srap_pkg;
    typedef logic [10:0] srap_addr_type;
    typedef logic [7:0]  srap_byte_type;
    typedef enum logic [1:0] {SRAP_IDLE, SRAP_WRITE, SRAP_READ}
        srap_port_state_type;
endpackage : srap_pkg

/* File: logic/srap_mem_if.sv */
// Purpose: Host-side memory request channel to the arbiter
// Assumes: Requester holds req until done
// Notes:   done is a one-cycle pulse, rdata valid with it
`timescale 1ns/10ps
`default_nettype none
interface srap_mem_if;
    logic                  req;
    logic                  we;
    srap_pkg::srap_addr_type addr;
    srap_pkg::srap_byte_type wdata;
    logic                  done;
    srap_pkg::srap_byte_type rdata;
    logic                  slow;
    modport ctl (output req, we, addr, wdata, slow, input done, rdata);
    modport arb (input req, we, addr, wdata, slow, output done, rdata);
endinterface : srap_mem_if
`default_nettype wire

/* File: logic/srap_ram_arb.sv */
// Purpose: Packet buffer RAM with arbitration between host and engine
// Assumes: Requesters hold req until their done pulse
// Notes:   One access per arbitration tick, alternating priority
`timescale 1ns/10ps
`default_nettype none
module srap_ram_arb
    import srap_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Host channel
    srap_mem_if.arb        mem,
    // Network engine channel
    input  wire logic      eng_req,
    input  wire logic      eng_we,
    input  wire srap_addr_type eng_addr,
    input  wire srap_byte_type eng_wdata,
    output logic           eng_done,
    output srap_byte_type  eng_rdata
);
    logic [7:0]    ram [0:2047];
    logic          tick_r;
    logic          prio_r;
    logic          hdone_r;
    logic          edone_r;
    srap_byte_type hrdata_r;
    srap_byte_type erdata_r;
    logic          h_ok;
    logic          e_ok;
    logic          go_h;
    logic          go_e;

    // Requests not yet answered
    assign h_ok = mem.req && !hdone_r;
    assign e_ok = eng_req && !edone_r;
    assign go_e = tick_r && e_ok && (prio_r || !h_ok);
    assign go_h = tick_r && h_ok && !go_e;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tick_r <= 1'b1;
        else if (mem.slow)
            tick_r <= ~tick_r;
        else
            tick_r <= 1'b1;
    end

    // Alternate priority so neither side starves
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prio_r <= 1'b0;
        else if (go_e)
            prio_r <= 1'b0;
        else if (go_h)
            prio_r <= 1'b1;
    end

    // Completion pulses
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hdone_r <= 1'b0;
            edone_r <= 1'b0;
        end
        else
        begin
            hdone_r <= go_h;
            edone_r <= go_e;
        end
    end

    // RAM array and read data; no reset on storage
    always_ff @(posedge clk)
    begin
        if (go_e && eng_we)
            ram[eng_addr] <= eng_wdata;
        else if (go_h && mem.we)
            ram[mem.addr] <= mem.wdata;
        if (go_e)
            erdata_r <= ram[eng_addr];
        if (go_h)
            hrdata_r <= ram[mem.addr];
    end

    assign mem.done  = hdone_r;
    assign mem.rdata = hrdata_r;
    assign eng_done  = edone_r;
    assign eng_rdata = erdata_r;

    chk_slow_spacing:
        assert property (@(posedge clk) disable iff (rst)
            (mem.slow && $past(mem.slow) && (go_h || go_e))
            |=> !(go_h || go_e))
        else $error("grant on consecutive cycles in slow mode");
endmodule : srap_ram_arb
`default_nettype wire

/* File: dv/srap_host_model.sv */
// Purpose: Host microcontroller model driving the register port
// Assumes: Callers resume just after a settled rising edge
// Notes:   Strobes last one cycle; idle write data never keeps its value
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.svh"
module srap_host_model
(
    // Clock
    input  wire logic                    clk,
    // Register port
    output logic [2:0]                   reg_addr,
    output srap_pkg::srap_byte_type      reg_wdata,
    output logic                         reg_wr,
    output logic                         reg_rd,
    input  wire srap_pkg::srap_byte_type reg_rdata,
    input  wire logic                    wr_ready
);
    import srap_pkg::*;

    // Quiet bus at time zero
    initial
    begin
        reg_addr  = 3'h0;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // One-cycle write, held off while the write buffer has no room
    task automatic wr(input logic [2:0] a, input srap_byte_type d);
        while (wr_ready !== 1'b1)
        begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // Stale data must not look valid
        #1;
    endtask : wr

    // One-cycle read; data taken in the single cycle it stands
    task automatic rd(input logic [2:0] a, output srap_byte_type d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // high byte with mode first, low commits, then a gap
    task automatic ptr_load(input srap_byte_type hi,
                            input srap_byte_type lo);
        wr(`SRAP_OFS_PTRH, hi);
        wr(`SRAP_OFS_PTRL, lo);
        repeat (8) @(posedge clk);
        #1;
    endtask : ptr_load
endmodule : srap_host_model
`default_nettype wire

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the sequential RAM access port
// Assumes: Host model tasks keep the register port protocol
// Notes:   Engine traffic is made here to contend for the RAM
`timescale 1ns/10ps
`default_nettype none
`include "srap_defs.svh"
module testbench;
    import srap_pkg::*;
    logic          clk;
    logic          rst;
    logic [2:0]    reg_addr;
    srap_byte_type reg_wdata;
    logic          reg_wr;
    logic          reg_rd;
    srap_byte_type reg_rdata;
    logic          wr_ready;
    srap_addr_type tx_base;
    srap_addr_type rx_base;
    logic          tx_en;
    logic          rx_en;
    logic          eng_req;
    logic          eng_we;
    srap_addr_type eng_addr;
    srap_byte_type eng_wdata;
    logic          eng_done;
    srap_byte_type eng_rdata;
    logic          hog;
    logic          mon;
    logic          low_seen;
    logic [3:0]    kk;
    int            error_cnt;
    int            checks_done;
    int            cycles;
    srap_byte_type d;

    srap_top DUT (.CLK(clk), .RST(rst), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .WR_READY(wr_ready),
        .TX_PAGE_BASE(tx_base), .RX_PAGE_BASE(rx_base),
        .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .ENG_REQ(eng_req),
        .ENG_WE(eng_we), .ENG_ADDR(eng_addr), .ENG_WDATA(eng_wdata),
        .ENG_DONE(eng_done), .ENG_RDATA(eng_rdata));

    srap_host_model host (.clk(clk), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wr_ready(wr_ready));

    // 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Engine holds its request until done; also watch for a full buffer
    always @(posedge clk)
    begin
        eng_req <= (hog || eng_req) && (eng_done !== 1'b1);
        if (mon && wr_ready === 1'b0)
            low_seen <= 1'b1;
    end

    // Ceiling far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    // Comparisons, one per kind of result
    task automatic cmp_byte(input string n, input srap_byte_type e,
                            input srap_byte_type g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_byte

    task automatic cmp_addr(input string n, input srap_addr_type e,
                            input srap_addr_type g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : cmp_addr

    task automatic cmp_bit(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : cmp_bit

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic test_end(input string n);
        $display("Test %s finished, mismatches so far %0d", n, error_cnt);
    endtask : test_end

    // One engine access; fields settle a cycle before the request
    task automatic eng_acc(input logic we, input srap_addr_type a,
                           input srap_byte_type wd,
                           output srap_byte_type rdat);
        int n;
        @(posedge clk);
        eng_we    <= we;
        eng_addr  <= a;
        eng_wdata <= wd;
        #1;
        hog = 1'b1;
        n = 0;
        while (eng_done !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        hog  = 1'b0;
        rdat = eng_rdata;
        cmp_bit("eng_done", 1'b1, eng_done);
    endtask : eng_acc

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Main sequence
    initial
    begin
        rst = 1'b1;
        hog = 1'b0;
        mon = 1'b0;
        low_seen = 1'b0;
        eng_req = 1'b0;
        eng_we = 1'b0;
        eng_addr = 11'h000;
        eng_wdata = 8'h00;
        error_cnt = 0;
        checks_done = 0;
        cycles = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        cmp_bit("wr_ready", 1'b1, wr_ready);
        host.wr(3'h5, 8'ha5);
        for (int i = 0; i < 8; i++)
            if (i != 4)
            begin
                host.rd(3'(i), d);
                cmp_byte("reset read", 8'h00, d);
            end
        test_end("reset");
        host.ptr_load(8'h87, 8'hfe);
        for (int i = 0; i < 4; i++)
            host.wr(`SRAP_OFS_DATA, 8'h30 + 8'(i));
        host.rd(`SRAP_OFS_PTRH, d);
        cmp_byte("ptr high", 8'h80, d);
        host.rd(`SRAP_OFS_PTRL, d);
        cmp_byte("ptr low", 8'h02, d);
        test_end("write burst");
        host.ptr_load(8'h87, 8'hfe);
        for (int i = 0; i < 4; i++)
        begin
            host.rd(`SRAP_OFS_DATA, d);
            cmp_byte("burst read", 8'h30 + 8'(i), d);
            idle(8);
        end
        test_end("read burst");
        host.ptr_load(8'h07, 8'hff);
        repeat (2)
        begin
            host.rd(`SRAP_OFS_DATA, d);
            cmp_byte("fixed read", 8'h31, d);
            idle(8);
        end
        host.rd(`SRAP_OFS_PTRL, d);
        cmp_byte("ptr held", 8'hff, d);
        host.wr(`SRAP_OFS_PTRH, 8'h01);
        host.rd(`SRAP_OFS_PTRH, d);
        cmp_byte("high only", 8'h07, d);
        host.wr(`SRAP_OFS_PTRL, 8'h00);
        host.rd(`SRAP_OFS_PTRH, d);
        cmp_byte("low commits", 8'h01, d);
        test_end("pointer load");
        eng_acc(1'b1, 11'h5a0, 8'hc5, d);
        host.ptr_load(8'h05, 8'ha0);
        host.rd(`SRAP_OFS_DATA, d);
        cmp_byte("engine byte", 8'hc5, d);
        eng_acc(1'b0, 11'h000, 8'h00, d);
        cmp_byte("engine read", 8'h32, d);
        test_end("engine");
        for (int k = 0; k < 16; k++)
        begin
            kk = 4'(k);
            host.wr(`SRAP_OFS_CMD, {2'b00, kk[3], kk[2:1],
                kk[0] ? `SRAP_CMD_RX : `SRAP_CMD_TX});
            cmp_bit("tx pulse", !kk[0], tx_en);
            cmp_bit("rx pulse", kk[0], rx_en);
            cmp_addr("page base", 11'(kk[2:1]) * 11'h200
                + 11'(kk[3]) * 11'h100, kk[0] ? rx_base : tx_base);
            idle(1);
            cmp_bit("pulse end", 1'b0, tx_en | rx_en);
        end
        host.wr(`SRAP_OFS_CMD, 8'h23);
        cmp_addr("tx base 23", 11'h100, tx_base);
        test_end("commands");
        host.wr(`SRAP_OFS_FSETUP, 8'h01);
        host.rd(`SRAP_OFS_FSETUP, d);
        cmp_byte("first setup", 8'h01, d);
        eng_acc(1'b0, 11'h700, 8'h00, d);
        host.ptr_load(8'h82, 8'h00);
        hog = 1'b1;
        mon = 1'b1;
        for (int i = 0; i < 6; i++)
            host.wr(`SRAP_OFS_DATA, 8'h50 + 8'(i));
        hog = 1'b0;
        mon = 1'b0;
        idle(20);
        cmp_bit("buffer full seen", 1'b1, low_seen);
        host.ptr_load(8'h82, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            idle(16);
            host.rd(`SRAP_OFS_DATA, d);
            cmp_byte("slow read", 8'h50 + 8'(i), d);
        end
        test_end("slow arbitration");
        final_report();
    end
endmodule : testbench
`default_nettype wire
